// ===== hw/fec_pkg.sv
/*
 * fec_pkg: constants and carrier types for the receive error counters.
 * Assumes a byte-addressed Avalon-MM slave with one 32-bit word per register.
 */
`default_nettype none
package fec_pkg;
   // -----------------------------------------------------------------
   // register indices (byte address is four times the index)
   // -----------------------------------------------------------------
   localparam logic [7:0] IDX_MODE     = 8'h40;
   localparam logic [7:0] IDX_CFG      = 8'h41;
   localparam logic [7:0] IDX_PV_HI    = 8'h44;
   localparam logic [7:0] IDX_PV_LO    = 8'h45;
   localparam logic [7:0] IDX_OOS_HI   = 8'h46;
   localparam logic [7:0] IDX_OOS_LO   = 8'h47;
   localparam logic [7:0] IDX_FEB_HI   = 8'h48;
   localparam logic [7:0] IDX_FEB_LO   = 8'h49;
   // -----------------------------------------------------------------
   // field positions and reset values
   // -----------------------------------------------------------------
   localparam int         MODE_E1      = 0;
   localparam int         MODE_ESF     = 1;
   localparam int         MODE_CRC4    = 2;
   localparam int         CFG_OOS_SEL  = 1;
   localparam int         CFG_FS_EN    = 2;
   localparam int         CFG_ACC_SEL  = 4;
   localparam int         CFG_UPD_SEL  = 5;
   localparam int         CFG_MAN_UPD  = 6;
   localparam logic [7:0] MODE_RST     = 8'h00;
   localparam logic [7:0] CFG_RST      = 8'h00;
   localparam logic [7:0] MODE_MASK    = 8'h07;
   localparam logic [7:0] CFG_MASK     = 8'h76;
   // -----------------------------------------------------------------
   // counters
   // -----------------------------------------------------------------
   localparam int         CNT_W        = 16;
   localparam logic [15:0] CNT_MAX     = 16'hFFFF;
   localparam int         CH_PV        = 0;
   localparam int         CH_OOS       = 1;
   localparam int         CH_FEB       = 2;
   localparam int         FRM_W        = 9;
   localparam logic [8:0] FRAMES_T1    = 9'd333;
   localparam logic [8:0] FRAMES_E1    = 9'd500;

   typedef struct packed {
      logic crc6_err;
      logic ft_err;
      logic fs_err;
      logic fps_err;
      logic mf_oos;
      logic crc4_err;
      logic fas_word_err;
      logic ebit_zero;
      logic frame_pulse;
      logic second_tick;
   } fec_rx_events_t;

   typedef struct packed {
      logic receive_sync_lost_flag;
      logic fas_lost;
      logic crc4_mf_lost;
      logic align_search;
   } fec_sync_t;

   typedef struct packed {
      logic [2:0][15:0] cnt;
      logic [2:0][15:0] lat;
      logic [7:0]       mode;
      logic [7:0]       cfg;
      logic             man_prev;
      logic [8:0]       frm;
      logic             ack;
      logic [7:0]       rdata;
   } fec_state_t;
endpackage
`default_nettype wire

// ===== hw/fec_error_counters.sv
/*
 * fec_error_counters: path violation, out-of-sync and far-end block error
 * counters with latch-and-clear update, read over Avalon-MM.
 * Assumes the framer's event pulses and sync flags come from logic on clk_sys
 * (the receive line clock), each event one cycle wide.
 */
// Notes on behaviour
// - T1 ESF: path counter adds one per failed CRC6 codeword.
// - T1 D4: path counter counts Ft errors, plus Fs errors when enabled.
// - T1: path counter holds while receive sync is lost.
// - E1: path counter adds one per CRC4 error.
// - E1: path counter holds on FAS or CRC4 sync loss, not CAS loss.
// - path count readable high byte 44h, low byte 45h.
// - T1, select clear: out-of-sync counter counts out-of-sync multiframes.
// - multiframe counting ignores the receive sync lost flag.
// - T1, select set: counts Ft errors in D4, FPS errors in ESF.
// - framing-bit counting holds while receive sync is lost.
// - E1: out-of-sync counter counts FAS word errors, holds on sync loss.
// - E1: FAS errors ignored while searching for alignment or multiframe.
// - E1 FAS error count cannot saturate in one second.
// - out-of-sync count readable high byte 46h, low byte 47h.
// - far-end block error counter works only in E1 mode.
// - with CRC4 multiframing, adds one per received E-bit equal to zero.
// - far-end counter holds on FAS or CRC4 sync loss, not CAS loss.
// - far-end count readable high byte 48h, low byte 49h.
// - all counters saturate at maximum instead of wrapping.
// - fast update every 333 frames T1, 500 frames E1, else each second.
// - manual bit rising loads registers next clock and clears counters.
`default_nettype none
module fec_error_counters
   import fec_pkg::*;
(
   input  wire logic           clk_sys,
   input  wire logic           rst,
   input  wire fec_rx_events_t rx_ev,
   input  wire fec_sync_t      rx_sync,
   input  wire logic [9:0]     avs_address,
   input  wire logic           avs_read,
   input  wire logic           avs_write,
   input  wire logic [31:0]    avs_writedata,
   input  wire logic [3:0]     avs_byteenable,
   output logic      [31:0]    avs_readdata,
   output logic                avs_waitrequest
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   fec_state_t  st_q;
   fec_state_t  st_d;
   logic [2:0]  inc;
   logic        is_e1;
   logic        is_esf;
   logic        los;
   logic        e1_halt;
   logic        man_edge;
   logic        auto_tick;
   logic        upd;
   logic [8:0]  frm_lim;
   logic [7:0]  idx;
   logic        req;

   assign idx             = avs_address[9:2];
   assign req             = avs_read | avs_write;
   assign avs_waitrequest = req & ~st_q.ack;
   assign avs_readdata    = {24'h000000, st_q.rdata};

   // ----------------------------------------------------------------
   // event qualification
   // ----------------------------------------------------------------
   always_comb begin
      is_e1   = st_q.mode[MODE_E1];
      is_esf  = st_q.mode[MODE_ESF];
      los     = rx_sync.receive_sync_lost_flag;
      e1_halt = rx_sync.fas_lost | rx_sync.crc4_mf_lost;
      inc     = 3'b000;
      if (is_e1) begin
         inc[CH_PV]  = rx_ev.crc4_err & ~e1_halt;
         inc[CH_OOS] = rx_ev.fas_word_err & ~los & ~rx_sync.align_search;
         inc[CH_FEB] = st_q.mode[MODE_CRC4] & rx_ev.ebit_zero & ~e1_halt;
      end else begin
         if (!los) begin
            if (is_esf) begin
               inc[CH_PV] = rx_ev.crc6_err;
            end else begin
               inc[CH_PV] = rx_ev.ft_err | (st_q.cfg[CFG_FS_EN] & rx_ev.fs_err);
            end
         end
         if (st_q.cfg[CFG_OOS_SEL]) begin
            inc[CH_OOS] = ~los & (is_esf ? rx_ev.fps_err : rx_ev.ft_err);
         end else begin
            inc[CH_OOS] = rx_ev.mf_oos;
         end
      end
   end

   // ----------------------------------------------------------------
   // update events
   // ----------------------------------------------------------------
   always_comb begin
      frm_lim   = is_e1 ? FRAMES_E1 : FRAMES_T1;
      man_edge  = st_q.cfg[CFG_ACC_SEL] & st_q.cfg[CFG_MAN_UPD] & ~st_q.man_prev;
      if (st_q.cfg[CFG_ACC_SEL]) begin
         auto_tick = 1'b0;
      end else if (st_q.cfg[CFG_UPD_SEL]) begin
         auto_tick = rx_ev.frame_pulse & (st_q.frm == frm_lim - 9'd1);
      end else begin
         auto_tick = rx_ev.second_tick;
      end
      upd = man_edge | auto_tick;
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      st_d          = st_q;
      st_d.man_prev = st_q.cfg[CFG_MAN_UPD];
      if (st_q.cfg[CFG_ACC_SEL] | ~st_q.cfg[CFG_UPD_SEL]) begin
         st_d.frm = 9'd0;
      end else if (rx_ev.frame_pulse) begin
         st_d.frm = (st_q.frm == frm_lim - 9'd1) ? 9'd0 : st_q.frm + 9'd1;
      end
      for (int i = 0; i < 3; i++) begin
         if (inc[i] && st_q.cnt[i] != CNT_MAX) begin
            st_d.cnt[i] = st_q.cnt[i] + 16'h0001;
         end
         if (upd) begin
            st_d.lat[i] = st_d.cnt[i];
            st_d.cnt[i] = 16'h0000;
         end
      end
      st_d.ack = req & ~st_q.ack;
      if (req && !st_q.ack) begin
         case (idx)
            IDX_MODE:   st_d.rdata = st_q.mode;
            IDX_CFG:    st_d.rdata = st_q.cfg;
            IDX_PV_HI:  st_d.rdata = st_q.lat[CH_PV][15:8];
            IDX_PV_LO:  st_d.rdata = st_q.lat[CH_PV][7:0];
            IDX_OOS_HI: st_d.rdata = st_q.lat[CH_OOS][15:8];
            IDX_OOS_LO: st_d.rdata = st_q.lat[CH_OOS][7:0];
            IDX_FEB_HI: st_d.rdata = st_q.lat[CH_FEB][15:8];
            IDX_FEB_LO: st_d.rdata = st_q.lat[CH_FEB][7:0];
            default:    st_d.rdata = 8'h00;
         endcase
      end
      // only mode and config take writes; count registers ignore them
      if (avs_write && st_q.ack && avs_byteenable[0]) begin
         if (idx == IDX_MODE) begin
            st_d.mode = avs_writedata[7:0] & MODE_MASK;
         end
         if (idx == IDX_CFG) begin
            st_d.cfg = avs_writedata[7:0] & CFG_MASK;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st_q <= '{cnt: '0, lat: '0, mode: MODE_RST, cfg: CFG_RST, man_prev: 1'b0,
                   frm: 9'd0, ack: 1'b0, rdata: 8'h00};
      end else begin
         st_q <= st_d;
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   sequence s_man_rise;
      st_q.cfg[CFG_ACC_SEL] & ~st_q.cfg[CFG_MAN_UPD] ##1 st_q.cfg[CFG_MAN_UPD];
   endsequence

   sequence s_cleared;
      st_q.cnt[CH_PV] == 16'h0000 && st_q.cnt[CH_OOS] == 16'h0000;
   endsequence

   AST_PV_ESF: assert property (~is_e1 & is_esf & rx_ev.crc6_err & ~los & ~upd
      & st_q.cnt[CH_PV] != CNT_MAX |=> st_q.cnt[CH_PV] == $past(st_q.cnt[CH_PV]) + 16'h0001)
      else $error("path counter missed a CRC6 error");
   AST_PV_FS_OFF: assert property (~is_e1 & ~is_esf & ~st_q.cfg[CFG_FS_EN]
      & rx_ev.fs_err & ~rx_ev.ft_err & ~upd |=> $stable(st_q.cnt[CH_PV]))
      else $error("Fs error counted while report disabled");
   AST_PV_T1_LOS: assert property (~is_e1 & los & ~upd |=> $stable(st_q.cnt[CH_PV]))
      else $error("path counter moved during sync loss");
   AST_PV_E1: assert property (is_e1 & rx_ev.crc4_err & ~e1_halt & ~upd
      & st_q.cnt[CH_PV] != CNT_MAX |=> st_q.cnt[CH_PV] == $past(st_q.cnt[CH_PV]) + 16'h0001)
      else $error("path counter missed a CRC4 error");
   AST_PV_E1_HALT: assert property (is_e1 & e1_halt & ~upd |=> $stable(st_q.cnt[CH_PV]))
      else $error("path counter moved on FAS or CRC4 loss");
   AST_OOS_MOS: assert property (~is_e1 & ~st_q.cfg[CFG_OOS_SEL] & rx_ev.mf_oos & los
      & ~upd & st_q.cnt[CH_OOS] != CNT_MAX |=> st_q.cnt[CH_OOS] != $past(st_q.cnt[CH_OOS]))
      else $error("multiframe out-of-sync not counted");
   AST_OOS_FBIT_LOS: assert property (~is_e1 & st_q.cfg[CFG_OOS_SEL] & los & ~upd
      |=> $stable(st_q.cnt[CH_OOS]))
      else $error("framing-bit count moved during sync loss");
   AST_OOS_E1_SEARCH: assert property (is_e1 & rx_sync.align_search & ~upd
      |=> $stable(st_q.cnt[CH_OOS]))
      else $error("FAS error counted while searching");
   AST_FEB_T1: assert property (~is_e1 & ~upd |=> $stable(st_q.cnt[CH_FEB]))
      else $error("far-end counter moved in T1 mode");
   AST_FEB_EBIT: assert property (is_e1 & st_q.mode[MODE_CRC4] & rx_ev.ebit_zero
      & ~e1_halt & ~upd & st_q.cnt[CH_FEB] != CNT_MAX
      |=> st_q.cnt[CH_FEB] == $past(st_q.cnt[CH_FEB]) + 16'h0001)
      else $error("E-bit zero not counted");
   AST_SATURATE: assert property (st_q.cnt[CH_PV] == CNT_MAX & ~upd
      |=> st_q.cnt[CH_PV] == CNT_MAX)
      else $error("path counter wrapped");
   AST_FAST_T1: assert property (~is_e1 & ~st_q.cfg[CFG_ACC_SEL] & st_q.cfg[CFG_UPD_SEL]
      & rx_ev.frame_pulse & st_q.frm == FRAMES_T1 - 9'd1
      |=> s_cleared and st_q.lat[CH_PV] == $past(st_d.lat[CH_PV]))
      else $error("fast update did not fire at frame 333");
   AST_MANUAL: assert property (s_man_rise |=> s_cleared ##0
      st_q.lat[CH_OOS] == $past(st_d.lat[CH_OOS]))
      else $error("manual update did not latch and clear");
   AST_READ_LO: assert property (avs_read & ~st_q.ack & idx == IDX_PV_LO
      |=> ~avs_waitrequest && avs_readdata[7:0] == $past(st_q.lat[CH_PV][7:0]))
      else $error("read did not return the latched count");

   // ----------------------------------------------------------------
   // path counter: further qualification checks
   // ----------------------------------------------------------------

   AST_PV_ESF_IDLE: assert property (~is_e1 & is_esf & ~rx_ev.crc6_err & ~upd
      |=> $stable(st_q.cnt[CH_PV]))
      else $error("path counter moved without a CRC6 error");

   AST_PV_D4_FT: assert property (~is_e1 & ~is_esf & ~los & rx_ev.ft_err & ~upd
      & st_q.cnt[CH_PV] != CNT_MAX
      |=> st_q.cnt[CH_PV] == $past(st_q.cnt[CH_PV]) + 16'h0001)
      else $error("path counter missed an Ft error");

   AST_PV_D4_FS: assert property (~is_e1 & ~is_esf & ~los & st_q.cfg[CFG_FS_EN]
      & rx_ev.fs_err & ~upd & st_q.cnt[CH_PV] != CNT_MAX
      |=> st_q.cnt[CH_PV] == $past(st_q.cnt[CH_PV]) + 16'h0001)
      else $error("path counter missed an enabled Fs error");

   AST_PV_E1_IDLE: assert property (is_e1 & ~rx_ev.crc4_err & ~upd
      |=> $stable(st_q.cnt[CH_PV]))
      else $error("path counter moved without a CRC4 error");

   AST_PV_E1_CAS: assert property (is_e1 & rx_ev.crc4_err & rx_sync.align_search
      & ~e1_halt & ~upd & st_q.cnt[CH_PV] != CNT_MAX
      |=> st_q.cnt[CH_PV] == $past(st_q.cnt[CH_PV]) + 16'h0001)
      else $error("path counter stopped on multiframe search alone");

   // ----------------------------------------------------------------
   // out-of-sync counter checks
   // ----------------------------------------------------------------

   AST_OOS_MF: assert property (~is_e1 & ~st_q.cfg[CFG_OOS_SEL] & rx_ev.mf_oos
      & ~los & ~upd & st_q.cnt[CH_OOS] != CNT_MAX
      |=> st_q.cnt[CH_OOS] == $past(st_q.cnt[CH_OOS]) + 16'h0001)
      else $error("out-of-sync multiframe not counted");

   AST_OOS_MF_IDLE: assert property (~is_e1 & ~st_q.cfg[CFG_OOS_SEL] & ~rx_ev.mf_oos
      & ~upd |=> $stable(st_q.cnt[CH_OOS]))
      else $error("out-of-sync counter moved without a multiframe");

   AST_OOS_FT: assert property (~is_e1 & ~is_esf & st_q.cfg[CFG_OOS_SEL] & rx_ev.ft_err
      & ~los & ~upd & st_q.cnt[CH_OOS] != CNT_MAX
      |=> st_q.cnt[CH_OOS] == $past(st_q.cnt[CH_OOS]) + 16'h0001)
      else $error("Ft pattern error not counted");

   AST_OOS_FPS: assert property (~is_e1 & is_esf & st_q.cfg[CFG_OOS_SEL] & rx_ev.fps_err
      & ~los & ~upd & st_q.cnt[CH_OOS] != CNT_MAX
      |=> st_q.cnt[CH_OOS] == $past(st_q.cnt[CH_OOS]) + 16'h0001)
      else $error("FPS pattern error not counted");

   AST_OOS_E1_FAS: assert property (is_e1 & rx_ev.fas_word_err & ~los
      & ~rx_sync.align_search & ~upd & st_q.cnt[CH_OOS] != CNT_MAX
      |=> st_q.cnt[CH_OOS] == $past(st_q.cnt[CH_OOS]) + 16'h0001)
      else $error("FAS word error not counted");

   AST_OOS_E1_LOS: assert property (is_e1 & los & ~upd
      |=> $stable(st_q.cnt[CH_OOS]))
      else $error("FAS count moved during sync loss");

   AST_OOS_E1_IDLE: assert property (is_e1 & ~rx_ev.fas_word_err & ~upd
      |=> $stable(st_q.cnt[CH_OOS]))
      else $error("FAS count moved without an error");

   AST_OOS_SAT: assert property (st_q.cnt[CH_OOS] == CNT_MAX & ~upd
      |=> st_q.cnt[CH_OOS] == CNT_MAX)
      else $error("out-of-sync counter wrapped");

   // ----------------------------------------------------------------
   // far-end block error counter checks
   // ----------------------------------------------------------------

   AST_FEB_NO_CRC4: assert property (is_e1 & ~st_q.mode[MODE_CRC4] & ~upd
      |=> $stable(st_q.cnt[CH_FEB]))
      else $error("far-end counter moved without CRC4 multiframing");

   AST_FEB_IDLE: assert property (is_e1 & ~rx_ev.ebit_zero & ~upd
      |=> $stable(st_q.cnt[CH_FEB]))
      else $error("far-end counter moved without an E-bit");

   AST_FEB_HALT: assert property (is_e1 & e1_halt & ~upd
      |=> $stable(st_q.cnt[CH_FEB]))
      else $error("far-end counter moved on FAS or CRC4 loss");

   AST_FEB_CAS: assert property (is_e1 & st_q.mode[MODE_CRC4] & rx_ev.ebit_zero
      & rx_sync.align_search & ~e1_halt & ~upd & st_q.cnt[CH_FEB] != CNT_MAX
      |=> st_q.cnt[CH_FEB] == $past(st_q.cnt[CH_FEB]) + 16'h0001)
      else $error("far-end counter stopped on multiframe search alone");

   AST_FEB_SAT: assert property (st_q.cnt[CH_FEB] == CNT_MAX & ~upd
      |=> st_q.cnt[CH_FEB] == CNT_MAX)
      else $error("far-end counter wrapped");

   // ----------------------------------------------------------------
   // update checks
   // ----------------------------------------------------------------

   AST_FAST_E1: assert property (is_e1 & ~st_q.cfg[CFG_ACC_SEL] & st_q.cfg[CFG_UPD_SEL]
      & rx_ev.frame_pulse & st_q.frm == FRAMES_E1 - 9'd1
      |=> s_cleared and st_q.lat[CH_OOS] == $past(st_d.lat[CH_OOS]))
      else $error("fast update did not fire at frame 500");

   AST_SECOND: assert property (~st_q.cfg[CFG_ACC_SEL] & ~st_q.cfg[CFG_UPD_SEL]
      & rx_ev.second_tick |=> s_cleared)
      else $error("one-second update did not clear");

   AST_FAST_MID: assert property (~st_q.cfg[CFG_ACC_SEL] & st_q.cfg[CFG_UPD_SEL]
      & ~(rx_ev.frame_pulse & st_q.frm == frm_lim - 9'd1) |=> $stable(st_q.lat))
      else $error("fast update fired between intervals");

   AST_MANUAL_ONLY: assert property (st_q.cfg[CFG_ACC_SEL] & ~man_edge
      |=> $stable(st_q.lat))
      else $error("latched counts moved without a manual edge");

   AST_MANUAL_FEB: assert property (s_man_rise |=> st_q.cnt[CH_FEB] == 16'h0000)
      else $error("manual update did not clear the far-end counter");

   // ----------------------------------------------------------------
   // register bus checks
   // ----------------------------------------------------------------

   AST_READ_PV_HI: assert property (avs_read & ~st_q.ack & idx == IDX_PV_HI
      |=> avs_readdata[7:0] == $past(st_q.lat[CH_PV][15:8]))
      else $error("path count high byte wrong");

   AST_READ_OOS_HI: assert property (avs_read & ~st_q.ack & idx == IDX_OOS_HI
      |=> avs_readdata[7:0] == $past(st_q.lat[CH_OOS][15:8]))
      else $error("out-of-sync count high byte wrong");

   AST_READ_OOS_LO: assert property (avs_read & ~st_q.ack & idx == IDX_OOS_LO
      |=> avs_readdata[7:0] == $past(st_q.lat[CH_OOS][7:0]))
      else $error("out-of-sync count low byte wrong");

   AST_READ_FEB_HI: assert property (avs_read & ~st_q.ack & idx == IDX_FEB_HI
      |=> avs_readdata[7:0] == $past(st_q.lat[CH_FEB][15:8]))
      else $error("far-end count high byte wrong");

   AST_READ_FEB_LO: assert property (avs_read & ~st_q.ack & idx == IDX_FEB_LO
      |=> avs_readdata[7:0] == $past(st_q.lat[CH_FEB][7:0]))
      else $error("far-end count low byte wrong");

   AST_WAIT_FIRST: assert property (req & ~st_q.ack |-> avs_waitrequest)
      else $error("request answered without a wait cycle");

   AST_READ_KEEP: assert property (avs_read & ~upd |=> $stable(st_q.lat))
      else $error("read disturbed the latched counts");

   AST_WRITE_RO: assert property (avs_write & st_q.ack & ~upd
      & idx >= IDX_PV_HI & idx <= IDX_FEB_LO |=> $stable(st_q.lat))
      else $error("write changed a count register");

   AST_WRITE_MODE: assert property (avs_write & st_q.ack & avs_byteenable[0]
      & idx == IDX_MODE |=> st_q.mode == $past(avs_writedata[7:0] & MODE_MASK))
      else $error("mode write did not land");

endmodule
`default_nettype wire

// ===== hw/fec_pad.sv
/*
 * fec_pad: intentionally empty of logic; holds no module.
 * Assumes nothing.
 */

// ===== verif/fec_line_model.sv
/*
 * fec_line_model: far-end line terminal seen through the framer, giving
 * registered event pulses and sync levels. Assumes the bench feeds it
 * the wanted pattern each cycle.
 */
`default_nettype none
module fec_line_model
   import fec_pkg::*;
(
   input  wire logic      clk_sys,
   input  wire logic [9:0] ev_in,
   input  wire logic [3:0] sync_in,
   output fec_rx_events_t  rx_ev,
   output fec_sync_t       rx_sync
);
   // ----------------------------------------------------------------
   // launch just after the edge, one cycle per pattern
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      rx_ev   <= fec_rx_events_t'(ev_in);
      rx_sync <= fec_sync_t'(sync_in);
   end
endmodule
`default_nettype wire

// ===== verif/tb_framer_error_counters.sv
/*
 * tb_framer_error_counters: random events against a counting model,
 * readback over Avalon-MM. Assumes the design's one-wait-cycle bus.
 */
`default_nettype none
module tb_framer_error_counters
   import fec_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_sys = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
   logic [9:0] avs_address = 10'h000, ev_in = 10'h000;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, rd, seed = 32'h12410F8D;
   logic [3:0] avs_byteenable = 4'hF, sync_in = 4'h0;
   logic avs_waitrequest;
   logic [7:0] mode_m = 8'h00, cfg_m = 8'h00;
   fec_rx_events_t rx_ev;
   fec_sync_t rx_sync;
   int miscompares = 0, total_checks = 0, frm = 0;
   int cnt[3], lat[3];
   logic prv, upd, e1, esf, sl, hold;
   logic [2:0] inc;
   logic [7:0] cfgs[8] = '{8'h10, 8'h14, 8'h12, 8'h10, 8'h12, 8'h10, 8'h10, 8'h12};
   logic [7:0] modes[8] = '{8'h00, 8'h00, 8'h00, 8'h02, 8'h02, 8'h01, 8'h05, 8'h05};
   always #25 clk_sys = ~clk_sys;
   fec_line_model far_u (.clk_sys(clk_sys), .ev_in(ev_in), .sync_in(sync_in),
      .rx_ev(rx_ev), .rx_sync(rx_sync));
   fec_error_counters dut_u (.clk_sys(clk_sys), .rst(rst), .rx_ev(rx_ev), .rx_sync(rx_sync),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
   // ----------------------------------------------------------------
   // reference counting model
   // ----------------------------------------------------------------
   always @(posedge clk_sys) begin
      if (rst) begin
         cnt = '{0, 0, 0};
         lat = '{0, 0, 0};
         prv = 1'b0;
         frm = 0;
      end else begin
         e1 = mode_m[0];
         esf = mode_m[1];
         sl = rx_sync.receive_sync_lost_flag;
         hold = rx_sync.fas_lost | rx_sync.crc4_mf_lost;
         inc[0] = e1 ? (!hold && rx_ev.crc4_err) : (!sl && (esf ? rx_ev.crc6_err :
            (rx_ev.ft_err || (cfg_m[2] && rx_ev.fs_err))));
         inc[1] = e1 ? (!sl && !rx_sync.align_search && rx_ev.fas_word_err) : (!cfg_m[1] ?
            rx_ev.mf_oos : (!sl && (esf ? rx_ev.fps_err : rx_ev.ft_err)));
         inc[2] = e1 && mode_m[2] && !hold && rx_ev.ebit_zero;
         for (int i = 0; i < 3; i++) begin
            if (inc[i] && cnt[i] < 65535) cnt[i]++;
         end
         upd = (cfg_m[4] && cfg_m[6] && !prv) || (!cfg_m[4] && !cfg_m[5] && rx_ev.second_tick);
         if (!cfg_m[4] && cfg_m[5]) begin
            if (rx_ev.frame_pulse) frm++;
            if (frm == (e1 ? 500 : 333)) begin
               upd = 1'b1;
               frm = 0;
            end
         end else frm = 0;
         prv = cfg_m[6];
         for (int i = 0; i < 3; i++) begin
            if (upd) begin
               lat[i] = cnt[i];
               cnt[i] = 0;
            end
         end
      end
   end
   // ----------------------------------------------------------------
   // bus, stimulus and checking tasks
   // ----------------------------------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
      int n;
      n = 0;
      @(posedge clk_sys);
      avs_address <= {idx, 2'b00};
      avs_read <= !wr;
      avs_write <= wr;
      avs_writedata <= {24'h0, wd};
      do begin
         @(posedge clk_sys);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      if (n >= 50) begin
         miscompares++;
         wrap_up();
      end
      rd = avs_readdata;
      if (wr && idx == IDX_CFG) cfg_m <= wd & CFG_MASK;
      if (wr && idx == IDX_MODE) mode_m <= wd & MODE_MASK;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic run(input int n, input logic [9:0] m, input logic [9:0] f);
      for (int k = 0; k < n; k++) begin
         @(posedge clk_sys);
         seed = xs(seed);
         ev_in <= (seed[9:0] & m) | f;
         sync_in <= seed[13:10] & seed[17:14] & seed[21:18];
      end
      @(posedge clk_sys);
      ev_in <= 10'h000;
      sync_in <= 4'h0;
      repeat (2) @(posedge clk_sys);
   endtask
   task automatic read_all();
      for (int i = 0; i < 6; i++) begin
         bus(1'b0, IDX_PV_HI + 8'(i), 8'h00);
         check(rd, {24'h0, 8'(lat[i / 2] >> ((i % 2) ? 0 : 8))});
      end
   endtask
   task automatic manual_update(input logic [7:0] c);
      bus(1'b1, IDX_CFG, c | 8'h40);
      bus(1'b1, IDX_CFG, c);
      read_all();
   endtask
   // ----------------------------------------------------------------
   // main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      #(50ns * 95000);
      miscompares++;
      wrap_up();
   end
   initial begin
      repeat (12) @(posedge clk_sys);
      rst <= 1'b0;
      read_all();
      bus(1'b0, 8'h4F, 8'h00);
      check(rd, 32'h0);
      for (int c = 0; c < 8; c++) begin
         bus(1'b1, IDX_MODE, modes[c]);
         bus(1'b1, IDX_CFG, cfgs[c]);
         run(400, 10'h3FC, 10'h000);
         bus(1'b1, IDX_PV_LO, 8'hA5);
         read_all();
         manual_update(cfgs[c]);
      end
      bus(1'b1, IDX_MODE, 8'h00);
      bus(1'b1, IDX_CFG, 8'h10);
      run(65600, 10'h000, 10'h020);
      manual_update(8'h10);
      bus(1'b1, IDX_CFG, 8'h20);
      run(800, 10'h3FE, 10'h000);
      bus(1'b1, IDX_MODE, 8'h05);
      run(1100, 10'h3FE, 10'h000);
      bus(1'b1, IDX_CFG, 8'h10);
      read_all();
      bus(1'b1, IDX_CFG, 8'h00);
      run(60, 10'h3FD, 10'h000);
      read_all();
      wrap_up();
   end
endmodule
`default_nettype wire
